/* File: fsw_flash_status_protect.sv */
// Purpose: status register and write protection of a serial nor flash
// Assumes: serial pins are asynchronous and sampled by clk
// Notes: rst stands for a power cycle
// Summary of operation
// - busy flag set during internal operations
// - latch clear rejects writes, program, erase
// - five range bits refuse program and erase
// - range bits change only if unprotected
// - chip erase only with low bits zero
// - complement bit inverts the protected region
// - guard 00 accepts writes when latch set
// - guard 01 refuses writes while protect low
// - guard 10 refuses writes until power cycle
// - guard 11 refuses writes until power cycle
// - quad bit turns protect pins to data
// - three one-time lock bits stay set until power cycle
// - suspend sets erase or program pause flag
// - resume and power cycle clear pause flags
// - scheme bit picks range or unit locks
// - all unit locks set at any reset
// - 254 block and 32 sector locks
// - lock, unlock, read one unit by address
// - lock all and unlock all commands
// - two-bit drive code, half by default
// - pin function bit selects pause or reset
// - latch set by allow, cleared by writes
// - protect pin low blocks range and guard
// - range code scales top or bottom region by powers
`include "fsw_defines.svh"
module fsw_flash_status_protect (
  // system
  input wire logic clk,
  input wire logic rst,
  // serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic hold_rst_n,
  output logic so,
  output logic so_oe,
  // state toward the array
  output logic busy,
  output logic [1:0] drive_code,
  output logic quad_mode,
  output logic [2:0] secure_ro
);
  // synchroniser stages: sclk, cs_n, si, wp_n, hold_rst_n
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [1:0] sync3_r; // delayed sclk and cs_n for edges
  // frame state
  logic [5:0] cnt_r, cnt_nxt; // bits received in frame
  logic [7:0] sh_r, sh_nxt; // input shifter
  logic [7:0] op_r, op_nxt; // opcode
  logic [23:0] addr_r, addr_nxt; // address
  logic [7:0] dat_r, dat_nxt; // first data byte
  logic so_r, so_nxt; // serial output bit
  // control state
  logic wel_r, wel_nxt; // write latch
  fsw_pkg::fsw_status_t st_r, st_nxt;
  logic [`FSW_LOCK_UNITS-1:0] lock_r, lock_nxt;
  fsw_pkg::fsw_state_t fsm_r, fsm_nxt;
  logic [9:0] tmr_r, tmr_nxt; // busy countdown
  logic erase_r, erase_nxt; // running op is an erase
  // decoded helpers
  logic rise, fall, cs_end, held, pin_reset, wp_low, clk_ok;
  logic byte_ok, idle, sr_ok, rd_on;
  logic [2:0] nbytes;
  logic [7:0] rx_byte, rd_byte;
  logic [23:0] status24, wr_word;
  logic addr_prot;
  logic [8:0] unit;

  // lock unit index: middle blocks, then bottom and top sectors
  function automatic logic [8:0] unit_idx(input logic [23:0] a);
    if (a[23:16] == 8'h00) begin
      unit_idx = 9'(`FSW_BLOCK_LOCKS) + {5'h00, a[15:12]};
    end else if (a[23:16] == 8'hFF) begin
      unit_idx = 9'(`FSW_TOP_SECT_BASE) + {5'h00, a[15:12]};
    end else begin
      unit_idx = {1'b0, a[23:16] - 8'h01};
    end
  endfunction : unit_idx

  // range decode with complement
  function automatic logic range_hit(input logic [23:0] a, input logic [4:0] bp,
                                     input logic cmp);
    logic [2:0] low;
    logic [2:0] lowc;
    logic [24:0] sz;
    logic hit;
    low = bp[2:0];
    lowc = (low > 3'h4) ? 3'h4 : low;
    sz = 25'h0000000;
    hit = 1'b0;
    if (low == 3'h7) begin
      hit = 1'b1;
    end else if (low != 3'h0) begin
      // sector sized steps cap at 32KB, block steps start at 1/64
      sz = bp[4] ? (25'h0000001 << (5'h0B + {2'h0, lowc}))
                 : (25'h0000001 << (5'h11 + {2'h0, low}));
      hit = bp[3] ? ({1'b0, a} < sz) : ({1'b0, a} >= (25'h1000000 - sz));
    end
    range_hit = hit ^ cmp;
  endfunction : range_hit

  // two-flop synchronisers and edge stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // idle pin levels: sclk parked low, selects and guards high
      sync1_r <= 5'h0B;
      sync2_r <= 5'h0B;
      sync3_r <= 2'h1;
    end else begin
      sync1_r <= {sclk, cs_n, si, wp_n, hold_rst_n};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r[4:3];
    end
  end

  assign held = !st_r.quad_pins_enable && !st_r.pin_reset_role && !sync2_r[0];
  assign pin_reset = !st_r.quad_pins_enable && st_r.pin_reset_role && !sync2_r[0];
  assign wp_low = !st_r.quad_pins_enable && !sync2_r[1];
  assign rise = sync2_r[4] && !sync3_r[1];
  assign fall = !sync2_r[4] && sync3_r[1];
  assign cs_end = sync2_r[3] && !sync3_r[0];
  assign clk_ok = !sync2_r[3] && !held;
  assign rx_byte = {sh_r[6:0], sync2_r[2]};
  assign nbytes = cnt_r[5:3];
  assign byte_ok = (cnt_r[2:0] == 3'h0) && (cnt_r != 6'h00);
  assign idle = (fsm_r == fsw_pkg::fsw_s_idle);
  assign sr_ok = !st_r.status_guard_hi && (!st_r.status_guard_lo || !wp_low);
  assign unit = unit_idx(addr_r);
  assign addr_prot = st_r.protect_scheme_select ? lock_r[unit]
                   : range_hit(addr_r, st_r.range_protect_bits,
                               st_r.range_complement_bit);

  assign status24 = {st_r.pin_reset_role, st_r.drive_code, 2'b00,
                     st_r.protect_scheme_select, 2'b00, st_r.erase_paused_flag,
                     st_r.range_complement_bit, st_r.secure_lock,
                     st_r.program_paused_flag, st_r.quad_pins_enable,
                     st_r.status_guard_hi, st_r.status_guard_lo,
                     st_r.range_protect_bits, wel_r, busy};
  // read data of the current read command
  always_comb begin
    rd_on = (cnt_r >= 6'h08) && ((op_r == `FSW_OP_RD_LO) ||
            (op_r == `FSW_OP_RD_MID) || (op_r == `FSW_OP_RD_HI));
    rd_byte = 8'h00;
    case (op_r)
      `FSW_OP_RD_LO: rd_byte = status24[7:0];
      `FSW_OP_RD_MID: rd_byte = status24[15:8];
      `FSW_OP_RD_HI: rd_byte = status24[23:16];
      `FSW_OP_RD_LOCK: begin
        rd_byte = {7'h00, lock_r[unit]};
        rd_on = (cnt_r >= 6'h20);
      end
      default: rd_byte = 8'h00;
    endcase
    // status write data placed in its word
    case (op_r)
      `FSW_OP_WR_LO: wr_word = {16'h0000, dat_r};
      `FSW_OP_WR_MID: wr_word = {8'h00, dat_r, 8'h00};
      default: wr_word = {dat_r, 16'h0000};
    endcase
  end

  // next state of frame and control
  always_comb begin
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    dat_nxt = dat_r;
    so_nxt = so_r;
    wel_nxt = wel_r;
    st_nxt = st_r;
    lock_nxt = lock_r;
    fsm_nxt = fsm_r;
    tmr_nxt = tmr_r;
    erase_nxt = erase_r;
    // internal operation countdown
    if (fsm_r == fsw_pkg::fsw_s_run) begin
      if (tmr_r == 10'h000) begin
        fsm_nxt = fsw_pkg::fsw_s_idle;
      end else begin
        tmr_nxt = tmr_r - 10'h001;
      end
    end
    if (cs_end) begin
      // frame closed: run command when it ended on a byte
      cnt_nxt = 6'h00;
      op_nxt = 8'h00;
      if (byte_ok) begin
        case (op_r)
          `FSW_OP_ALLOW: if (nbytes == 3'h1 && idle) wel_nxt = 1'b1;
          `FSW_OP_FORBID: if (nbytes == 3'h1 && idle) wel_nxt = 1'b0;
          `FSW_OP_WR_LO, `FSW_OP_WR_MID, `FSW_OP_WR_HI: begin
            if (nbytes == 3'h2 && idle && wel_r) begin
              wel_nxt = 1'b0;
              if (sr_ok) begin
                fsm_nxt = fsw_pkg::fsw_s_run;
                tmr_nxt = 10'(`FSW_SR_WR_CYC);
                erase_nxt = 1'b0;
                if (op_r == `FSW_OP_WR_LO) begin
                  st_nxt.status_guard_lo = wr_word[`FSW_GUARD_LO_BIT];
                  st_nxt.range_protect_bits = wr_word[`FSW_RANGE_LSB +: 5];
                end else if (op_r == `FSW_OP_WR_MID) begin
                  st_nxt.status_guard_hi = wr_word[`FSW_GUARD_HI_BIT];
                  st_nxt.quad_pins_enable = wr_word[`FSW_QUAD_BIT];
                  st_nxt.range_complement_bit = wr_word[`FSW_COMPL_BIT];
                  st_nxt.secure_lock = st_r.secure_lock | wr_word[`FSW_SECLK_LSB +: 3];
                end else begin
                  st_nxt.protect_scheme_select = wr_word[`FSW_SCHEME_BIT];
                  st_nxt.drive_code = wr_word[`FSW_DRV_LSB +: 2];
                  st_nxt.pin_reset_role = wr_word[`FSW_PINFN_BIT];
                end
              end
            end
          end
          `FSW_OP_PROG, `FSW_OP_ER4K, `FSW_OP_ER32K, `FSW_OP_ER64K: begin
            if (idle && wel_r && (nbytes == 3'h4 || (op_r == `FSW_OP_PROG && nbytes >= 3'h5))) begin
              wel_nxt = 1'b0;
              if (!addr_prot) begin
                fsm_nxt = fsw_pkg::fsw_s_run;
                erase_nxt = (op_r != `FSW_OP_PROG);
                tmr_nxt = (op_r == `FSW_OP_PROG) ? 10'(`FSW_PROG_CYC) : 10'(`FSW_ERASE_CYC);
              end
            end
          end
          `FSW_OP_CHIP_A, `FSW_OP_CHIP_B: begin
            if (nbytes == 3'h1 && idle && wel_r) begin
              wel_nxt = 1'b0;
              if (st_r.range_protect_bits[2:0] == 3'h0 && !st_r.range_complement_bit) begin
                fsm_nxt = fsw_pkg::fsw_s_run;
                erase_nxt = 1'b1;
                tmr_nxt = 10'(`FSW_ERASE_CYC);
              end
            end
          end
          `FSW_OP_PAUSE: if (nbytes == 3'h1 && fsm_r == fsw_pkg::fsw_s_run) begin
            fsm_nxt = fsw_pkg::fsw_s_halt;
            tmr_nxt = tmr_r;
            if (erase_r) st_nxt.erase_paused_flag = 1'b1;
            else st_nxt.program_paused_flag = 1'b1;
          end
          `FSW_OP_RESUME: if (nbytes == 3'h1 && fsm_r == fsw_pkg::fsw_s_halt) begin
            fsm_nxt = fsw_pkg::fsw_s_run;
            st_nxt.erase_paused_flag = 1'b0;
            st_nxt.program_paused_flag = 1'b0;
          end
          `FSW_OP_LOCK: if (nbytes == 3'h4 && idle) lock_nxt[unit] = 1'b1;
          `FSW_OP_UNLOCK: if (nbytes == 3'h4 && idle) lock_nxt[unit] = 1'b0;
          `FSW_OP_LOCK_ALL: if (nbytes == 3'h1 && idle) lock_nxt = '1;
          `FSW_OP_UNLOCK_ALL: if (nbytes == 3'h1 && idle) lock_nxt = '0;
          default: lock_nxt = lock_r;
        endcase
      end
    end else if (clk_ok && rise) begin
      // shift in msb first; long frames wrap within the data phase
      sh_nxt = rx_byte;
      cnt_nxt = (cnt_r == 6'h3F) ? 6'h38 : cnt_r + 6'h01;
      if (cnt_r[2:0] == 3'h7) begin
        if (cnt_r[5:3] == 3'h0) begin
          op_nxt = rx_byte;
        end else if (cnt_r[5:3] <= 3'h3) begin
          addr_nxt = {addr_r[15:0], rx_byte};
        end
        if (cnt_r[5:3] == 3'h1) dat_nxt = rx_byte;
      end
    end else if (clk_ok && fall && rd_on) begin
      so_nxt = rd_byte[3'h7 - cnt_r[2:0]];
    end
    if (pin_reset) begin
      lock_nxt = '1;
      wel_nxt = 1'b0;
      fsm_nxt = fsw_pkg::fsw_s_idle;
      cnt_nxt = 6'h00;
      op_nxt = 8'h00;
      st_nxt.erase_paused_flag = 1'b0;
      st_nxt.program_paused_flag = 1'b0;
    end
  end

  // registers of frame and control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 6'h00;
      sh_r <= 8'h00;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      dat_r <= 8'h00;
      so_r <= 1'b0;
      wel_r <= 1'b0;
      st_r <= `FSW_STATUS_RST;
      lock_r <= '1;
      fsm_r <= fsw_pkg::fsw_s_idle;
      tmr_r <= 10'h000;
      erase_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      dat_r <= dat_nxt;
      so_r <= so_nxt;
      wel_r <= wel_nxt;
      st_r <= st_nxt;
      lock_r <= lock_nxt;
      fsm_r <= fsm_nxt;
      tmr_r <= tmr_nxt;
      erase_r <= erase_nxt;
    end
  end

  assign busy = (fsm_r == fsw_pkg::fsw_s_run);
  assign so = so_r;
  assign so_oe = clk_ok && rd_on;
  assign drive_code = st_r.drive_code;
  assign quad_mode = st_r.quad_pins_enable;
  assign secure_ro = st_r.secure_lock;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cmd1(logic [7:0] code);
    cs_end && byte_ok && nbytes == 3'h1 && op_r == code && !pin_reset;
  endsequence
  property p_busy_start;
    idle && fsm_nxt == fsw_pkg::fsw_s_run |=> busy ##1 (busy || idle);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");
  property p_latch_gate;
    cs_end && !wel_r && idle && !pin_reset |=> idle && $stable(st_r.range_protect_bits);
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("write ran without latch");
  property p_guard_lock;
    st_r.status_guard_hi |=> $stable(st_r.range_protect_bits) && st_r.status_guard_hi;
  endproperty
  a_guard_lock: assert property (p_guard_lock) else $error("locked status changed");
  property p_pin_guard;
    !st_r.status_guard_hi && st_r.status_guard_lo && wp_low && !rise
      |=> $stable(st_r.range_protect_bits) && $stable(st_r.status_guard_lo);
  endproperty
  a_pin_guard: assert property (p_pin_guard) else $error("protect pin ignored");
  property p_pin_reset;
    pin_reset |=> (&lock_r) && !wel_r;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("locks not set by reset");
  property p_pause;
    s_cmd1(`FSW_OP_PAUSE) ##0 fsm_r == fsw_pkg::fsw_s_run
      |=> (fsm_r == fsw_pkg::fsw_s_halt) && (st_r.erase_paused_flag || st_r.program_paused_flag);
  endproperty
  a_pause: assert property (p_pause) else $error("suspend flag not set");
  property p_resume;
    s_cmd1(`FSW_OP_RESUME) ##0 fsm_r == fsw_pkg::fsw_s_halt
      |=> !st_r.erase_paused_flag && !st_r.program_paused_flag && busy;
  endproperty
  a_resume: assert property (p_resume) else $error("resume left flags");
  property p_otp;
    1'b1 |=> (st_r.secure_lock & $past(st_r.secure_lock)) == $past(st_r.secure_lock);
  endproperty
  a_otp: assert property (p_otp) else $error("one-time lock bit cleared");
  property p_chip_gate;
    (s_cmd1(`FSW_OP_CHIP_A) or s_cmd1(`FSW_OP_CHIP_B)) ##0 idle
      ##0 (st_r.range_protect_bits[2:0] != 3'h0 || st_r.range_complement_bit) |=> idle;
  endproperty
  a_chip_gate: assert property (p_chip_gate) else $error("chip erase not refused");
endmodule : fsw_flash_status_protect

/* File: fsw_defines.svh */
// Purpose: constants of the flash status and write-protect block
// Assumes: 100 MHz system clock
// Notes: opcodes, bit positions, reset values and busy times
`ifndef FSW_DEFINES_SVH
`define FSW_DEFINES_SVH
// command codes
`define FSW_OP_ALLOW 8'h06
`define FSW_OP_FORBID 8'h04
`define FSW_OP_RD_LO 8'h05
`define FSW_OP_RD_MID 8'h35
`define FSW_OP_RD_HI 8'h15
`define FSW_OP_WR_LO 8'h01
`define FSW_OP_WR_MID 8'h31
`define FSW_OP_WR_HI 8'h11
`define FSW_OP_PROG 8'h02
`define FSW_OP_ER4K 8'h20
`define FSW_OP_ER32K 8'h52
`define FSW_OP_ER64K 8'hD8
`define FSW_OP_CHIP_A 8'h60
`define FSW_OP_CHIP_B 8'hC7
`define FSW_OP_PAUSE 8'h75
`define FSW_OP_RESUME 8'h7A
`define FSW_OP_LOCK 8'h36
`define FSW_OP_UNLOCK 8'h39
`define FSW_OP_RD_LOCK 8'h3D
`define FSW_OP_LOCK_ALL 8'h7E
`define FSW_OP_UNLOCK_ALL 8'h98
// status bit positions in the 24-bit word
`define FSW_RANGE_LSB 2
`define FSW_GUARD_LO_BIT 7
`define FSW_GUARD_HI_BIT 8
`define FSW_QUAD_BIT 9
`define FSW_SECLK_LSB 11
`define FSW_COMPL_BIT 14
`define FSW_SCHEME_BIT 18
`define FSW_DRV_LSB 21
`define FSW_PINFN_BIT 23
// reset of the stored fields: drive code 2'b10, all else zero
`define FSW_STATUS_RST 18'h10000
// lock array layout
`define FSW_BLOCK_LOCKS 254
`define FSW_TOP_SECT_BASE 270
`define FSW_LOCK_UNITS 286
// busy times in ns and in clock cycles
`define FSW_CLK_NS 10
`define FSW_SR_WR_NS 1000
`define FSW_PROG_NS 2000
`define FSW_ERASE_NS 4000
`define FSW_SR_WR_CYC ((`FSW_SR_WR_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`define FSW_PROG_CYC ((`FSW_PROG_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`define FSW_ERASE_CYC ((`FSW_ERASE_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`endif

/* File: fsw_pkg.sv */
// Purpose: types of the flash status and write-protect block
// Assumes: nothing
// Notes: stored status fields travel as one struct
package fsw_pkg;
  // one-hot operation states
  typedef enum logic [2:0] {
    fsw_s_idle = 3'b001,
    fsw_s_run = 3'b010,
    fsw_s_halt = 3'b100
  } fsw_state_t;
  // stored status fields, msb first
  typedef struct packed {
    logic pin_reset_role;
    logic [1:0] drive_code;
    logic protect_scheme_select;
    logic erase_paused_flag;
    logic range_complement_bit;
    logic [2:0] secure_lock;
    logic program_paused_flag;
    logic quad_pins_enable;
    logic status_guard_hi;
    logic status_guard_lo;
    logic [4:0] range_protect_bits;
  } fsw_status_t;
endpackage : fsw_pkg

/* File: fsw_host_model.sv */
// Purpose: spi host model for the flash status block
// Assumes: mode 0, sclk parked low between frames, 80 ns period
// Notes: so is sampled late in each high phase, long after it settles
module fsw_host_model (
  // serial pins toward the flash
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  // frame alignment
  input wire logic clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // deselected and quiet at start
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end
  // one frame: tx msb first, rx keeps the last eight so bits
  task automatic xfer(input logic [39:0] tx, input int nb, output logic [7:0] rx);
    @(posedge clk);
    #1 cs_n = 1'h0;
    for (int i = 0; i < nb; i++) begin
      // opcode, address and data shift msb first
      si = tx[39-i];
      #40 sclk = 1'h1;
      #36 rx = {rx[6:0], so};
      #4 sclk = 1'h0;
    end
    #40 cs_n = 1'h1;
    // released line flips, never a stale bit
    si = ~si;
    // deselect gap well above three clocks
    #80;
  endtask : xfer
endmodule : fsw_host_model

/* File: testbench.sv */
// Purpose: self-checking bench of the flash status and protect block
// Assumes: host model drives the serial pins at 80 ns per bit
// Notes: table of status writes first, then hand-written cases
`include "fsw_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // table case: latch first, pin level, write, read, expectation
  typedef struct packed {
    logic w;
    logic wp;
    logic [7:0] op;
    logic [7:0] d;
    logic [7:0] rop;
    logic [7:0] e;
  } fsw_row_t;
  // design pins
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic wp_n = 1'h1;
  logic hold_rst_n = 1'h1;
  logic sclk, cs_n, si, so, so_oe, busy, quad_mode;
  logic [1:0] drive_code;
  logic [2:0] secure_ro;
  // tallies and scratch byte
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] v;
  fsw_row_t rows [13] = '{
    '{1'h0, 1'h1, 8'h01, 8'h1C, 8'h05, 8'h00},
    '{1'h1, 1'h1, 8'h01, 8'h1C, 8'h05, 8'h1C},
    '{1'h1, 1'h1, 8'h11, 8'hFF, 8'h15, 8'hE4},
    '{1'h1, 1'h1, 8'h31, 8'h42, 8'h35, 8'h42},
    '{1'h1, 1'h0, 8'h31, 8'h08, 8'h35, 8'h08},
    '{1'h1, 1'h1, 8'h31, 8'h90, 8'h35, 8'h18},
    '{1'h1, 1'h1, 8'h01, 8'h80, 8'h05, 8'h80},
    '{1'h1, 1'h0, 8'h01, 8'h84, 8'h05, 8'h80},
    '{1'h1, 1'h1, 8'h01, 8'h84, 8'h05, 8'h84},
    '{1'h1, 1'h1, 8'h01, 8'h04, 8'h05, 8'h04},
    '{1'h1, 1'h1, 8'h31, 8'h19, 8'h35, 8'h19},
    '{1'h1, 1'h1, 8'h01, 8'h00, 8'h05, 8'h04},
    '{1'h1, 1'h1, 8'h31, 8'h00, 8'h35, 8'h19}
  };
  // 100 MHz clock
  always #5 clk = ~clk;
  // block under test
  fsw_flash_status_protect dut_u (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .hold_rst_n(hold_rst_n), .so(so), .so_oe(so_oe), .busy(busy),
    .drive_code(drive_code), .quad_mode(quad_mode), .secure_ro(secure_ro)
  );
  // far-side host
  fsw_host_model host_u (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .clk(clk));
  // compare and tally
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // reset held four clocks, then sync settle
  task automatic do_reset;
    @(posedge clk);
    #1 rst = 1'h1;
    repeat (4) @(posedge clk);
    #1 rst = 1'h0;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // one-byte command
  task automatic op1(input logic [7:0] op);
    host_u.xfer({op, 32'h0}, 8, v);
  endtask : op1
  // opcode plus 24-bit address, nb bits long
  task automatic ad(input logic [7:0] op, input logic [23:0] a, input int nb);
    host_u.xfer({op, a, 8'hA5}, nb, v);
  endtask : ad
  // status read, one byte back
  task automatic rd(input logic [7:0] op, output logic [7:0] r);
    host_u.xfer({op, 32'h0}, 16, r);
  endtask : rd
  // bounded wait for the internal operation to end
  task automatic wait_idle;
    int n = 0;
    while (busy !== 1'h0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk("busy settles", 8'h00, busy);
  endtask : wait_idle
  // status write, with or without the latch command
  task automatic wr(input logic w, input logic [7:0] op, input logic [7:0] d);
    if (w) begin
      op1(`FSW_OP_ALLOW);
    end
    host_u.xfer({op, d, 24'h0}, 16, v);
    wait_idle();
  endtask : wr
  // latched program of one byte, busy shows acceptance
  task automatic prog(input logic [23:0] a, input logic e, input string nm);
    op1(`FSW_OP_ALLOW);
    ad(`FSW_OP_PROG, a, 40);
    chk(nm, e, busy);
    wait_idle();
  endtask : prog
  // unit lock state read back in bit 0 of byte five
  task automatic lk(input logic [23:0] a, input logic e);
    ad(`FSW_OP_RD_LOCK, a, 40);
    chk("lock bit", e, v[0]);
  endtask : lk
  // values right after a reset
  task automatic post_reset;
    chk("drive code", 8'h02, drive_code);
    chk("quad mode", 8'h00, quad_mode);
    chk("secure locks", 8'h00, secure_ro);
    chk("busy", 8'h00, busy);
    chk("output enable", 8'h00, so_oe);
    rd(`FSW_OP_RD_MID, v);
    chk("mid byte", 8'h00, v);
    rd(`FSW_OP_RD_HI, v);
    chk("high byte", 8'h40, v);
    lk(24'h020000, 1'h1);
  endtask : post_reset
  // main sequence
  initial begin
    do_reset();
    post_reset();
    $display("test reset finished");
    foreach (rows[i]) begin
      @(posedge clk);
      #1 wp_n = rows[i].wp;
      wr(rows[i].w, rows[i].op, rows[i].d);
      rd(rows[i].rop, v);
      chk("table byte", rows[i].e, v); // table rows
    end
    #1 wp_n = 1'h1;
    chk("drive pins", 8'h03, drive_code);
    chk("secure pins", 8'h03, secure_ro);
    $display("test table finished");
    // power cycle frees the guard
    do_reset();
    post_reset();
    $display("test power cycle finished");
    // pause role of the shared pin drops a whole frame
    @(posedge clk);
    #1 hold_rst_n = 1'h0;
    op1(`FSW_OP_ALLOW);
    @(posedge clk);
    #1 hold_rst_n = 1'h1;
    rd(`FSW_OP_RD_LO, v);
    chk("held frame", 8'h00, v);
    op1(`FSW_OP_ALLOW);
    rd(`FSW_OP_RD_LO, v);
    chk("latch set", 8'h02, v);
    op1(`FSW_OP_FORBID);
    ad(`FSW_OP_ER4K, 24'h000000, 32);
    chk("erase after forbid", 8'h00, busy);
    $display("test pause pin and latch finished");
    // single and global unit locks
    ad(`FSW_OP_UNLOCK, 24'h020000, 32);
    lk(24'h020000, 1'h0);
    ad(`FSW_OP_LOCK, 24'h020000, 32);
    lk(24'h020000, 1'h1);
    op1(`FSW_OP_UNLOCK_ALL);
    lk(24'hFFF000, 1'h0);
    op1(`FSW_OP_LOCK_ALL);
    lk(24'hFFF000, 1'h1);
    $display("test unit locks finished");
    // range protect, busy, chip erase, suspend
    wr(1'h1, `FSW_OP_WR_LO, 8'h04);
    prog(24'hFC0000, 1'h0, "top program");
    op1(`FSW_OP_ALLOW);
    ad(`FSW_OP_ER64K, 24'hFC0000, 32);
    chk("top erase refused", 8'h00, busy);
    op1(`FSW_OP_ALLOW);
    ad(`FSW_OP_ER32K, 24'h000000, 32);
    chk("low erase runs", 8'h01, busy);
    wait_idle();
    op1(`FSW_OP_ALLOW);
    ad(`FSW_OP_PROG, 24'h000000, 40);
    chk("program busy", 8'h01, busy);
    rd(`FSW_OP_RD_LO, v);
    chk("status in program", 8'h05, v);
    wait_idle();
    op1(`FSW_OP_ALLOW);
    op1(`FSW_OP_CHIP_B);
    chk("chip erase refused", 8'h00, busy);
    wr(1'h1, `FSW_OP_WR_LO, 8'h00);
    op1(`FSW_OP_ALLOW);
    op1(`FSW_OP_CHIP_A);
    chk("chip erase runs", 8'h01, busy);
    op1(`FSW_OP_PAUSE);
    rd(`FSW_OP_RD_MID, v);
    chk("erase paused", 8'h80, v);
    op1(`FSW_OP_RESUME);
    rd(`FSW_OP_RD_MID, v);
    chk("resumed", 8'h00, v);
    chk("busy again", 8'h01, busy);
    wait_idle();
    $display("test range and erase finished");
    // complement, then unit-lock scheme
    wr(1'h1, `FSW_OP_WR_MID, 8'h40);
    wr(1'h1, `FSW_OP_WR_LO, 8'h04);
    prog(24'h000000, 1'h0, "complement low");
    prog(24'hFC0000, 1'h1, "complement top");
    wr(1'h1, `FSW_OP_WR_HI, 8'h44);
    prog(24'hFC0000, 1'h0, "scheme locked");
    ad(`FSW_OP_UNLOCK, 24'hFC0000, 32);
    prog(24'hFC0000, 1'h1, "scheme unlocked");
    // shared pin as reset relocks units
    wr(1'h1, `FSW_OP_WR_HI, 8'hC4);
    @(posedge clk);
    #1 hold_rst_n = 1'h0;
    repeat (3) @(posedge clk);
    #1 hold_rst_n = 1'h1;
    lk(24'hFC0000, 1'h1);
    $display("test schemes finished");
    // both guard bits set
    wr(1'h1, `FSW_OP_WR_LO, 8'h80);
    wr(1'h1, `FSW_OP_WR_MID, 8'h01);
    wr(1'h1, `FSW_OP_WR_LO, 8'h04);
    rd(`FSW_OP_RD_LO, v);
    chk("guard both set", 8'h80, v);
    $display("test guard finished");
    wrap_up();
  end
  // watchdog: run needs about 180 us, allow 800 us
  initial begin
    #800000;
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule : testbench
